/* File: rtl/cfio_core.sv */
// Decoder and executor for the condition flag and literal operand instructions.
// Notes on behaviour
// - Signed compare sets flag when first >= second.
// - Branch true/false tests flag, else falls through.
// - Add immediate leaves flag untouched.
// - Compare-equal immediate sets flag on equality.
// - Byte literal comes from instruction, no fetch.
// - Word and long literals come from memory.
// - Literal load reads PC-relative, writes destination.
// - Absolute address loaded, then register-indirect access.
// - Wide displacement into index register, then indexed.
// - Move, add, compare-equal literals sign-extended.
// - Test and logic literals zero-extended.
// - PC-relative address: sign-extend, double, add PC.
// - Byte and word memory reads sign-extended.
`timescale 1ns/1ps
`default_nettype none
module cfio_core (
	input wire logic clk,
	input wire logic rst,
	input wire cfio_pkg::cfio_insn_t insn_in,
	output logic insn_ready,
	output logic [31:0] pc,
	output cfio_pkg::cfio_dreq_t dreq,
	input wire cfio_pkg::cfio_drsp_t drsp,
	output logic cond_flag,
	output logic retired
);
	import cfio_pkg::*;

	typedef enum logic [0:0] {ST_DECODE, ST_WAIT_DATA} cfio_state_t;

	// ****************************************************************
	// State
	// ****************************************************************
	cfio_state_t state;
	logic [31:0] regs [CFIO_NUM_REGS];
	logic [3:0] dest;
	cfio_size_t pend_size;
	logic [31:0] next_pc;

	// ****************************************************************
	// Field decode
	// ****************************************************************
	logic [15:0] ir;
	logic [3:0] opc, rn, rm, sub;
	logic [7:0] imm8;
	logic [31:0] rn_val, rm_val, idx_val;
	logic [31:0] imm_sext, imm_zext, pcrel_addr;
	logic fire;

	assign ir = insn_in.insn;
	assign opc = ir[CFIO_OPC_HI:CFIO_OPC_LO];
	assign rn = ir[CFIO_RN_HI:CFIO_RN_LO];
	assign rm = ir[CFIO_RM_HI:CFIO_RM_LO];
	assign sub = ir[CFIO_SUB_HI:CFIO_SUB_LO];
	assign imm8 = ir[CFIO_IMM_HI:CFIO_IMM_LO];
	assign rn_val = regs[rn];
	assign rm_val = regs[rm];
	assign idx_val = regs[CFIO_INDEX_REG];
	// Literal extensions; which one is used depends on the operation class.
	assign imm_sext = {{24{imm8[7]}}, imm8};
	assign imm_zext = {24'h000000, imm8};
	// Displacement is signed and counted in halfwords.
	assign pcrel_addr = pc + {{23{imm8[7]}}, imm8, 1'b0};

	// The decoder only takes an instruction while no data read is pending.
	assign insn_ready = (state == ST_DECODE);
	assign fire = insn_in.valid & insn_ready;

	// ****************************************************************
	// Data read extension
	// ****************************************************************
	logic [31:0] load_val;
	cfio_extend u_ext (
		.raw(drsp.rdata),
		.size(pend_size),
		.sign_ext(1'b1),
		.ext(load_val)
	);

	// ****************************************************************
	// Memory request decode
	// ****************************************************************
	logic is_load;
	logic [31:0] load_addr;
	cfio_size_t load_size;
	always_comb begin
		is_load = 1'b0;
		load_addr = CFIO_ZERO;
		load_size = CFIO_SIZE_LONG;
		if (opc == OPC_WORD_LIT) begin
			// Wide literals never sit in the instruction; they are fetched.
			is_load = 1'b1;
			load_addr = pcrel_addr;
			load_size = CFIO_SIZE_WORD;
		end else if (opc == OPC_LONG_LIT) begin
			is_load = 1'b1;
			load_addr = pcrel_addr;
			load_size = CFIO_SIZE_LONG;
		end else if (opc == OPC_MEM) begin
			is_load = 1'b1;
			// Size code 3 has no carrier member, so it travels as a longword read.
			load_size = (sub[1:0] > SZ_LONG) ? CFIO_SIZE_LONG : cfio_size_t'(sub[1:0]);
			if (sub[CFIO_MEM_IDX_BIT]) begin
				load_addr = rm_val + idx_val;
			end else begin
				load_addr = rm_val;
			end
		end
	end

	// ****************************************************************
	// Sequencer: one read outstanding; the next access waits for it.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_DECODE;
			dest <= CFIO_INDEX_REG;
			pend_size <= CFIO_SIZE_LONG;
			dreq <= '0;
		end else begin
			unique case (state)
				ST_DECODE: begin
					if (fire && is_load) begin
						state <= ST_WAIT_DATA;
						dest <= rn;
						pend_size <= load_size;
						dreq.req <= 1'b1;
						dreq.addr <= load_addr;
						dreq.size <= load_size;
					end
				end
				ST_WAIT_DATA: begin
					if (drsp.ack) begin
						state <= ST_DECODE;
						dreq.req <= 1'b0;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Program counter
	// ****************************************************************
	always_comb begin
		next_pc = pc + CFIO_PC_STEP;
		if (opc == OPC_GRP8) begin
			if ((rn == G8_BRANCH_TRUE && cond_flag) ||
				(rn == G8_BRANCH_FALSE && !cond_flag)) begin
				next_pc = pcrel_addr;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc <= CFIO_PC_RESET;
		end else if (fire) begin
			pc <= next_pc;
		end
	end

	// ****************************************************************
	// Condition flag: only compares and test write it, everything else holds it.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			cond_flag <= 1'b0;
		end else if (fire) begin
			if (opc == OPC_REG_OPS && sub == SUB_COMPARE_SIGNED_GREATER_EQUAL) begin
				cond_flag <= ($signed(rn_val) >= $signed(rm_val));
			end else if (opc == OPC_REG_OPS && sub == SUB_COMPARE_EQUAL_OP) begin
				cond_flag <= (rn_val == rm_val);
			end else if (opc == OPC_GRP8 && rn == G8_COMPARE_EQUAL_OP_IMM) begin
				cond_flag <= (idx_val == imm_sext);
			end else if (opc == OPC_LOGIC_IMM && rn == LG_TEST) begin
				cond_flag <= ((idx_val & imm_zext) == CFIO_ZERO);
			end
			// Add immediate and all other ops fall through here.
		end
	end

	// ****************************************************************
	// Register file writes: loaded data or single-cycle results.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < CFIO_NUM_REGS; i++) begin
				regs[i] <= CFIO_ZERO;
			end
		end else if (state == ST_WAIT_DATA && drsp.ack) begin
			regs[dest] <= load_val;
		end else if (fire) begin
			unique case (opc)
				OPC_TRANSFER_IMM: regs[rn] <= imm_sext;
				OPC_ADD_IMM: regs[rn] <= rn_val + imm_sext;
				OPC_LOGIC_IMM: begin
					// Logic literals are zero-extended, so AND clears bits 31:8.
					if (rn == LG_AND) regs[CFIO_INDEX_REG] <= idx_val & imm_zext;
					else if (rn == LG_XOR) regs[CFIO_INDEX_REG] <= idx_val ^ imm_zext;
					else if (rn == LG_OR) regs[CFIO_INDEX_REG] <= idx_val | imm_zext;
				end
				default: ;
			endcase
		end
	end

	// Retire pulse: a non-load issues, or a read completes.
	always_ff @(posedge clk) begin
		if (rst) begin
			retired <= 1'b0;
		end else begin
			retired <= (fire && !is_load) || (state == ST_WAIT_DATA && drsp.ack);
		end
	end
endmodule // cfio_core
`default_nettype wire

/* File: rtl/cfio_extend.sv */
// Sign or zero extension of byte and word operands to a longword.
`timescale 1ns/1ps
`default_nettype none
module cfio_extend (
	input wire logic [31:0] raw,
	input wire cfio_pkg::cfio_size_t size,
	input wire logic sign_ext,
	output logic [31:0] ext
);
	import cfio_pkg::*;

	// Pick the top bit of the narrow value and replicate it, or zeros.
	always_comb begin
		unique case (size)
			CFIO_SIZE_BYTE: ext = {{24{sign_ext & raw[7]}}, raw[7:0]};
			CFIO_SIZE_WORD: ext = {{16{sign_ext & raw[15]}}, raw[15:0]};
			default: ext = raw;
		endcase
	end
endmodule // cfio_extend
`default_nettype wire

/* File: rtl/cfio_pkg.sv */
// Package of encodings, field positions and carrier types for the flag and literal decoder.
package cfio_pkg;

	// ****************************************************************
	// Widths and field positions
	// ****************************************************************
	localparam int CFIO_REG_W = 32;
	localparam int CFIO_INSN_W = 16;
	localparam int CFIO_NUM_REGS = 16;
	localparam int CFIO_OPC_HI = 15;
	localparam int CFIO_OPC_LO = 12;
	localparam int CFIO_RN_HI = 11;
	localparam int CFIO_RN_LO = 8;
	localparam int CFIO_RM_HI = 7;
	localparam int CFIO_RM_LO = 4;
	localparam int CFIO_IMM_HI = 7;
	localparam int CFIO_IMM_LO = 0;
	localparam int CFIO_SUB_HI = 3;
	localparam int CFIO_SUB_LO = 0;
	localparam logic [3:0] CFIO_INDEX_REG = 4'h0;
	localparam logic [31:0] CFIO_PC_RESET = 32'h00000000;
	localparam logic [31:0] CFIO_PC_STEP = 32'h00000002;
	localparam logic [31:0] CFIO_ZERO = 32'h00000000;

	// ****************************************************************
	// Major opcodes (bits 15:12)
	// ****************************************************************
	localparam logic [3:0] OPC_REG_OPS = 4'h3;   // Register-register group, sub-op in 3:0.
	localparam logic [3:0] OPC_ADD_IMM = 4'h7;
	localparam logic [3:0] OPC_GRP8 = 4'h8;      // Compare/branch with imm8, Rn field selects.
	localparam logic [3:0] OPC_WORD_LIT = 4'h9;
	localparam logic [3:0] OPC_LONG_LIT = 4'hD;
	localparam logic [3:0] OPC_TRANSFER_IMM = 4'hE;
	localparam logic [3:0] OPC_LOGIC_IMM = 4'hC;
	localparam logic [3:0] OPC_MEM = 4'h6;       // Indirect and indexed loads, sub-op in 3:0.

	// Sub-ops of OPC_REG_OPS.
	localparam logic [3:0] SUB_COMPARE_SIGNED_GREATER_EQUAL = 4'h3;
	localparam logic [3:0] SUB_COMPARE_EQUAL_OP = 4'h0;
	// Selectors in the Rn field of OPC_GRP8.
	localparam logic [3:0] G8_COMPARE_EQUAL_OP_IMM = 4'h8;
	localparam logic [3:0] G8_BRANCH_TRUE = 4'h9;
	localparam logic [3:0] G8_BRANCH_FALSE = 4'hB;
	// Selectors in the Rn field of OPC_LOGIC_IMM (operate on the index register).
	localparam logic [3:0] LG_TEST = 4'h8;
	localparam logic [3:0] LG_AND = 4'h9;
	localparam logic [3:0] LG_XOR = 4'hA;
	localparam logic [3:0] LG_OR = 4'hB;
	// Sub-ops of OPC_MEM: size in bits 1:0, bit 2 selects indexed.
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam int CFIO_MEM_IDX_BIT = 2;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef enum logic [1:0] {
		CFIO_SIZE_BYTE = 2'h0,
		CFIO_SIZE_WORD = 2'h1,
		CFIO_SIZE_LONG = 2'h2
	} cfio_size_t;

	typedef struct packed {
		logic req;
		logic [31:0] addr;
		cfio_size_t size;
	} cfio_dreq_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} cfio_drsp_t;

	typedef struct packed {
		logic valid;
		logic [15:0] insn;
	} cfio_insn_t;

endpackage

/* File: tb/cfio_mem_model.sv */
// Data memory model that answers each read after a random wait.
`timescale 1ns/1ps
`default_nettype none
module cfio_mem_model
	import cfio_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire cfio_pkg::cfio_dreq_t dreq,
	output cfio_pkg::cfio_drsp_t drsp
);
	int unsigned wait_n;
	// Data toggles between answers, so a stale value is never taken for a reply.
	always_ff @(posedge clk) begin
		drsp.ack <= 1'b0;
		drsp.rdata <= ~drsp.rdata;
		if (rst) begin
			drsp.rdata <= '0;
			wait_n <= 0;
		end else if (dreq.req && !drsp.ack) begin
			if (wait_n == 0) begin
				drsp.ack <= 1'b1;
				drsp.rdata <= {dreq.addr[15:0] ^ 16'h5A3C, ~dreq.addr[15:0]};
				wait_n <= $urandom_range(3, 0);
			end else begin
				wait_n <= wait_n - 1;
			end
		end
	end
endmodule // cfio_mem_model
`default_nettype wire

/* File: tb/cfio_monitor.sv */
// Port checker for the flag, branch and literal fetch behaviour of the core.
`timescale 1ns/1ps
`default_nettype none
module cfio_monitor
	import cfio_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire cfio_pkg::cfio_insn_t insn_in,
	input wire logic insn_ready,
	input wire logic [31:0] pc,
	input wire cfio_pkg::cfio_dreq_t dreq,
	input wire cfio_pkg::cfio_drsp_t drsp,
	input wire logic cond_flag,
	input wire logic retired
);
	// ****
	// Decoded view of the instruction being taken.
	// ****
	logic tk;
	logic [3:0] op;
	logic [3:0] rn;
	logic [31:0] dsp;
	assign tk = insn_in.valid && insn_ready;
	assign op = insn_in.insn[15:12];
	assign rn = insn_in.insn[11:8];
	assign dsp = {{23{insn_in.insn[7]}}, insn_in.insn[7:0], 1'b0};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	ready_vs_read_a: assert property (
		insn_ready == !dreq.req) else $error("ready while read open");
	read_hold_a: assert property (
		dreq.req && !drsp.ack |=> dreq.req && $stable(dreq.addr)) else $error("read dropped");
	lit_addr_a: assert property (
		tk && (op == OPC_WORD_LIT || op == OPC_LONG_LIT) |=>
		dreq.req && dreq.addr == $past(pc) + $past(dsp)) else $error("literal address");
	lit_size_a: assert property (
		tk && op == OPC_LONG_LIT |=> dreq.size == CFIO_SIZE_LONG) else $error("literal size");
	imm_nofetch_a: assert property (
		tk && (op == OPC_TRANSFER_IMM || op == OPC_ADD_IMM) |=> !dreq.req) else $error("fetch");
	add_flag_a: assert property (
		tk && op == OPC_ADD_IMM |=> $stable(cond_flag)) else $error("add moved flag");
	transfer_flag_a: assert property (
		tk && op == OPC_TRANSFER_IMM |=> $stable(cond_flag)) else $error("move moved flag");
	branch_pc_a: assert property (
		tk && op == OPC_GRP8 && (rn == G8_BRANCH_TRUE || rn == G8_BRANCH_FALSE) |=>
		pc == $past(pc) + (($past(cond_flag) == ($past(rn) == G8_BRANCH_TRUE)) ?
		$past(dsp) : CFIO_PC_STEP)) else $error("branch target");
	load_retire_a: assert property (
		dreq.req && drsp.ack |=> retired && insn_ready) else $error("load not retired");
endmodule // cfio_monitor
bind cfio_core cfio_monitor mon (.clk, .rst, .insn_in, .insn_ready, .pc, .dreq, .drsp,
	.cond_flag, .retired);
`default_nettype wire

/* File: tb/tb_cfio_core.sv */
// Self-checking bench comparing the core with a reference model.
`timescale 1ns/1ps
`default_nettype none
module tb_cfio_core;
	import cfio_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	cfio_insn_t insn_in = '0;
	logic insn_ready, cond_flag, retired, m_flag, ld;
	logic [31:0] pc, m_pc, ea;
	logic [1:0] sz;
	cfio_dreq_t dreq;
	cfio_drsp_t drsp;
	int miscompares = 0;
	int checked = 0;
	logic [31:0] r [16];
	logic [15:0] dir [12] = '{16'hE0FF, 16'hC9FF, 16'h88FF, 16'hC800, 16'h7001, 16'h8B04,
		16'h8904, 16'h9105, 16'h6216, 16'hD180, 16'h6212, 16'h3013};
	always #4 clk = ~clk;
	cfio_core dut (.clk, .rst, .insn_in, .insn_ready, .pc, .dreq, .drsp, .cond_flag, .retired);
	cfio_mem_model mem (.clk, .rst, .dreq, .drsp);
	// ****
	// Reference model and checks.
	// ****
	task automatic cmp(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Loads update the model at once; the core stalls issue until the data lands.
	task automatic upd(input logic [15:0] w);
		logic [3:0] n;
		logic [31:0] i, z, d, p, v;
		n = w[11:8];
		i = {{24{w[7]}}, w[7:0]};
		z = {24'h0, w[7:0]};
		d = {i[30:0], 1'b0};
		p = m_pc;
		m_pc = p + 2;
		ld = 1'b0;
		case (w[15:12])
			OPC_REG_OPS: m_flag = w[0] ? $signed(r[n]) >= $signed(r[w[7:4]]) : r[n] == r[w[7:4]];
			OPC_ADD_IMM: r[n] = r[n] + i;
			OPC_TRANSFER_IMM: r[n] = i;
			OPC_GRP8: begin
				if (n == G8_COMPARE_EQUAL_OP_IMM)
					m_flag = r[0] == i;
				else if (m_flag == (n == G8_BRANCH_TRUE))
					m_pc = p + d;
			end
			OPC_LOGIC_IMM: begin
				if (n == LG_TEST)
					m_flag = (r[0] & z) == 0;
				r[0] = n == LG_AND ? r[0] & z : n == LG_XOR ? r[0] ^ z : n == LG_OR ? r[0] | z : r[0];
			end
			OPC_MEM: begin
				ld = 1'b1;
				sz = w[1:0] == 2'h3 ? 2'h2 : w[1:0];
				ea = r[w[7:4]] + (w[2] ? r[0] : 0);
			end
			default: begin
				ld = 1'b1;
				sz = w[14] ? 2'h2 : 2'h1;
				ea = p + d;
			end
		endcase
		v = {ea[15:0] ^ 16'h5A3C, ~ea[15:0]};
		if (ld)
			r[n] = sz == 2 ? v : sz == 1 ? {{16{v[15]}}, v[15:0]} : {{24{v[7]}}, v[7:0]};
	endtask
	task automatic issue(input logic [15:0] w);
		int n;
		n = 0;
		while (insn_ready !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) begin
			cmp(1'b0, "stuck");
			report_and_stop();
		end
		// Valid stays up between calls so it is never written twice in one step; the
		// next call replaces the word, and while a read is open the core refuses it.
		insn_in = '{1'b1, w};
		@(negedge clk);
		upd(w);
		cmp(pc === m_pc && cond_flag === m_flag, "pc or flag");
		cmp(retired === !ld, "retire pulse");
		if (ld)
			cmp(dreq.req === 1'b1 && dreq.addr === ea && dreq.size === sz, "read");
	endtask
	// Random words keep every selector field inside the decoded set.
	function automatic logic [15:0] rnd();
		logic [3:0] ops [8];
		logic [15:0] w;
		ops = '{OPC_REG_OPS, OPC_ADD_IMM, OPC_GRP8, OPC_WORD_LIT, OPC_LONG_LIT, OPC_TRANSFER_IMM,
			OPC_LOGIC_IMM, OPC_MEM};
		w = 16'($urandom);
		w[15:12] = ops[$urandom_range(7, 0)];
		if (w[15:12] == OPC_REG_OPS)
			w[3:0] = w[0] ? SUB_COMPARE_SIGNED_GREATER_EQUAL : SUB_COMPARE_EQUAL_OP;
		if (w[15:12] == OPC_GRP8)
			w[11:8] = {2'b10, w[9], w[9] | w[8]};
		if (w[15:12] == OPC_LOGIC_IMM)
			w[11:8] = {2'b10, w[9:8]};
		if (w[15:12] == OPC_MEM)
			w[3] = 1'b0;
		return w;
	endfunction
	// Main sequence.
	initial begin
		void'($urandom(38));
		m_pc = '0;
		m_flag = 1'b0;
		foreach (r[k])
			r[k] = '0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		foreach (dir[k])
			issue(dir[k]);
		$display("directed test done");
		repeat (400)
			issue(rnd());
		$display("random test done");
		report_and_stop();
	end
endmodule // tb_cfio_core
`default_nettype wire
